// ---- rtl/dct_pkg.sv ----
// Shared constants for the dual counter/timer output and control block
package dct_pkg;
   // ======================================================
   // Register indices; byte address is four times the index
   localparam int IDX_T8CTL  = 0;
   localparam int IDX_COMMON = 1;
   localparam int IDX_T16CTL = 2;
   localparam int IDX_STAT   = 3;
   localparam int IDX_MASK   = 4;
   localparam int IDX_T8LD   = 5;
   localparam int IDX_T16LD  = 6;
   localparam int NUM_REGS   = 7;
   // ======================================================
   // Field positions
   localparam int B8_EN      = 7;
   localparam int B8_IE      = 1;
   localparam int BC_DEMOD   = 7;
   localparam int BC_OM_HI   = 3;
   localparam int BC_OM_LO   = 2;
   localparam int BC_INIT8   = 1;
   localparam int BC_INIT16  = 0;
   localparam int B16_EN     = 7;
   localparam int B16_SINGLE = 6;
   localparam int B16_TOUT   = 5;
   localparam int ST_T8      = 0;
   localparam int ST_T16     = 1;
   localparam int ST_RISE    = 2;
   localparam int ST_FALL    = 3;
   // ======================================================
   // Encodings and reset values
   localparam logic [1:0]  OM_NORMAL   = 2'h0;
   localparam logic [1:0]  OM_PINGPONG = 2'h1;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam logic [7:0]  RST_REG8    = 8'h00;
   localparam logic [3:0]  RST_STAT    = 4'h0;
   localparam logic [7:0]  RST_T8LD    = 8'hFF;
   localparam logic [15:0] RST_T16LD   = 16'hFFFF;
   localparam logic [7:0]  T8_DEMOD_WRAP = 8'hFF;
   // ======================================================
   // Counting tick: period in ns, and the cycle count derived from it
   localparam int CLK_PERIOD_NS  = 10;
   localparam int TICK_PERIOD_NS = 40;
   localparam int TICK_DIV       = TICK_PERIOD_NS / CLK_PERIOD_NS;
endpackage : dct_pkg

// ---- rtl/dct_edge_detect.sv ----
// Rising and falling edge detector for the timer input pin
`timescale 1ns/1ns
module dct_edge_detect (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic sig_in,
   output logic      rise,
   output logic      fall
);
   logic prev_ff;

   // Previous sample; input is already synchronous to aclk
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= sig_in;
      end
   end

   assign rise = sig_in & ~prev_ff;
   assign fall = ~sig_in & prev_ff;
endmodule // dct_edge_detect

// ---- rtl/dct_down_counter.sv ----
// Loadable down counter shared by the 8-bit and 16-bit timers
`timescale 1ns/1ns
module dct_down_counter #(
   parameter int W = 8
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   input  wire logic         tick,
   output logic     [W-1:0]  count,
   output logic              at_zero
);
   logic [W-1:0] cnt_ff;

   // Load has priority over the count tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= '0;
      end else if (load) begin
         cnt_ff <= load_val;
      end else if (tick) begin
         cnt_ff <= W'(cnt_ff - 1'b1);
      end
   end

   assign count   = cnt_ff;
   assign at_zero = (cnt_ff == '0);
endmodule // dct_down_counter

// ---- rtl/dct_timer_ctrl.sv ----
// Top: register file, output levels and edge flags of the timer pair
// Behaviour
// - In transmit mode the 8-bit output takes its initial-level bit when the 8-bit counter starts.
// - While the 8-bit counter is off its output shows the inverse of its initial-level bit.
// - In demodulation mode a rising input edge sets the rise flag; writing one clears it.
// - In transmit mode the 16-bit output takes its initial-level bit when the 16-bit counter starts.
// - The 16-bit initial-level bit acts only in normal or alternating output mode.
// - While the 16-bit counter is off its output shows the inverse of its initial-level bit.
// - In demodulation mode a falling input edge sets the fall flag; writing one clears it.
// - Bit 7 of the 16-bit control register reads run state; writing starts or stops; resets to 0.
// - Bit 6 picks modulo-N or single pass in transmit; in demodulation it masks only the edge reload of the 16-bit counter.
// - Bit 5 is a sticky timeout flag, reset 0, cleared by writing one, kept by writing zero.
// - In 8-bit demodulation counting an interrupt is raised if enabled and counting resumes from FFh.
`timescale 1ns/1ns
module dct_timer_ctrl #(
   parameter int ADDR_W = 8
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic [2:0]        arprot,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              timer_in,
   output logic                   eight_bit_timer_output,
   output logic                   sixteen_bit_timer_output,
   output logic                   irq
);
   import dct_pkg::*;

   // ======================================================
   // Declarations
   logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, irq_ff;
   logic [1:0]  bresp_ff, rresp_ff;
   logic [31:0] rdata_ff, wdata_ff;
   logic        aw_have_ff, w_have_ff, aw_ok_ff;
   logic [2:0]  aw_idx_ff;
   logic [3:0]  wstrb_ff;
   logic [7:0]  timer8_control_reg_ff, timer_common_control_reg_ff, timer16_control_reg_ff;
   logic [3:0]  stat_ff, mask_ff;
   logic [7:0]  t8ld_ff;
   logic [15:0] t16ld_ff;
   logic        eight_bit_timer_output_ff, sixteen_bit_timer_output_ff, run8_d_ff, run16_d_ff, tick_ff;
   logic [7:0]  div_ff;
   logic [7:0]  cnt8;
   logic [15:0] cnt16;
   logic        zero8, zero16, rise_ev, fall_ev;

   // ======================================================
   // Address decode, used for both write and read channels
   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      addr_ok = (a[ADDR_W-1:5] == '0) && (int'(a[4:2]) < NUM_REGS);
   endfunction

   // ======================================================
   // AXI4-Lite write channel: address and data taken in either order
   wire aw_take   = awvalid & awready_ff;
   wire w_take    = wvalid & wready_ff;
   wire wr_fire   = aw_have_ff & w_have_ff;
   wire nxt_aw    = (aw_have_ff | aw_take) & ~wr_fire;
   wire nxt_w     = (w_have_ff | w_take) & ~wr_fire;
   wire nxt_bv    = wr_fire | (bvalid_ff & ~bready);
   wire wr_ok     = wr_fire & aw_ok_ff;
   wire lane0     = wstrb_ff[0];
   wire lane1     = wstrb_ff[1];
   wire wr8ctl    = wr_ok & lane0 & (aw_idx_ff == 3'(IDX_T8CTL));
   wire wrcom     = wr_ok & lane0 & (aw_idx_ff == 3'(IDX_COMMON));
   wire wr16ctl   = wr_ok & lane0 & (aw_idx_ff == 3'(IDX_T16CTL));
   wire wrstat    = wr_ok & lane0 & (aw_idx_ff == 3'(IDX_STAT));
   wire wrmask    = wr_ok & lane0 & (aw_idx_ff == 3'(IDX_MASK));
   wire wr8ld     = wr_ok & lane0 & (aw_idx_ff == 3'(IDX_T8LD));
   wire wr16ld    = wr_ok & (aw_idx_ff == 3'(IDX_T16LD));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff <= 1'b0;
         w_have_ff  <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
         aw_ok_ff   <= 1'b0;
         aw_idx_ff  <= 3'h0;
         wdata_ff   <= 32'h0;
         wstrb_ff   <= 4'h0;
      end else begin
         aw_have_ff <= nxt_aw;
         w_have_ff  <= nxt_w;
         awready_ff <= ~nxt_aw & ~nxt_bv;
         wready_ff  <= ~nxt_w & ~nxt_bv;
         bvalid_ff  <= nxt_bv;
         if (aw_take) begin
            aw_ok_ff  <= addr_ok(awaddr);
            aw_idx_ff <= awaddr[4:2];
         end
         if (w_take) begin
            wdata_ff <= wdata;
            wstrb_ff <= wstrb;
         end
         if (wr_fire) begin
            bresp_ff <= aw_ok_ff ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // ======================================================
   // AXI4-Lite read channel: one word a read, answer on the next edge
   wire ar_take = arvalid & arready_ff;
   wire nxt_rv  = ar_take | (rvalid_ff & ~rready);
   wire [2:0]  ar_idx = araddr[4:2];
   logic [31:0] rd_word;

   always_comb begin
      rd_word = 32'h0;
      unique case (ar_idx)
         3'(IDX_T8CTL):  rd_word[7:0]  = timer8_control_reg_ff;
         3'(IDX_COMMON): rd_word[7:0]  = timer_common_control_reg_ff;
         3'(IDX_T16CTL): rd_word[7:0]  = timer16_control_reg_ff;
         3'(IDX_STAT):   rd_word[3:0]  = stat_ff;
         3'(IDX_MASK):   rd_word[3:0]  = mask_ff;
         3'(IDX_T8LD):   rd_word[7:0]  = t8ld_ff;
         3'(IDX_T16LD):  rd_word[15:0] = t16ld_ff;
         default:        rd_word       = 32'h0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0;
         rresp_ff   <= RESP_OKAY;
      end else begin
         arready_ff <= ~nxt_rv;
         rvalid_ff  <= nxt_rv;
         if (ar_take) begin
            rdata_ff <= addr_ok(araddr) ? rd_word : 32'h0;
            rresp_ff <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // ======================================================
   // Counting tick divider; one-cycle enable pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_ff  <= 8'h00;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= (div_ff == 8'(TICK_DIV - 1));
         div_ff  <= (div_ff == 8'(TICK_DIV - 1)) ? 8'h00 : 8'(div_ff + 8'h01);
      end
   end

   // ======================================================
   // Timer state and edge decode
   wire demod    = timer_common_control_reg_ff[BC_DEMOD];
   wire init8    = timer_common_control_reg_ff[BC_INIT8];
   wire init16   = timer_common_control_reg_ff[BC_INIT16];
   wire [1:0] om = timer_common_control_reg_ff[BC_OM_HI:BC_OM_LO];
   wire init_eff = (om == OM_NORMAL) | (om == OM_PINGPONG);
   wire run8     = timer8_control_reg_ff[B8_EN];
   wire run16    = timer16_control_reg_ff[B16_EN];
   wire single   = timer16_control_reg_ff[B16_SINGLE];
   wire start8   = run8 & ~run8_d_ff;
   wire start16  = run16 & ~run16_d_ff;
   wire term8    = run8 & ~start8 & tick_ff & zero8;                 // A start is never terminal
   wire term16   = run16 & ~start16 & tick_ff & zero16;              // Counter may sit at zero after reset
   wire edge16   = demod & ~single & (rise_ev | fall_ev);
   wire stop16   = term16 & ~demod & single;
   wire [7:0] ld8 = (demod & term8) ? T8_DEMOD_WRAP : t8ld_ff;

   dct_edge_detect u_edge (
      .aclk    (aclk),
      .aresetn (aresetn),
      .sig_in  (timer_in),
      .rise    (rise_ev),
      .fall    (fall_ev)
   );

   dct_down_counter #(.W(8)) u_cnt8 (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .load     (start8 | term8),
      .load_val (ld8),
      .tick     (run8 & tick_ff),
      .count    (cnt8),
      .at_zero  (zero8)
   );

   dct_down_counter #(.W(16)) u_cnt16 (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .load     (start16 | (term16 & ~stop16) | (run16 & edge16)),
      .load_val (t16ld_ff),
      .tick     (run16 & tick_ff),
      .count    (cnt16),
      .at_zero  (zero16)
   );

   // ======================================================
   // Control registers; sticky flags let a new event win over a clear
   wire c1   = wdata_ff[BC_INIT8];
   wire c0   = wdata_ff[BC_INIT16];
   wire nxt_init8  = demod ? ((rise_ev) | (init8 & ~(wrcom & c1)))
                           : (wrcom ? c1 : init8);
   wire nxt_init16 = demod ? ((fall_ev) | (init16 & ~(wrcom & c0)))
                           : (wrcom ? c0 : init16);
   wire nxt_tout   = term16 | (timer16_control_reg_ff[B16_TOUT]
                     & ~(wr16ctl & wdata_ff[B16_TOUT]));
   wire nxt_run16  = stop16 ? 1'b0 : (wr16ctl ? wdata_ff[B16_EN] : run16);
   wire [3:0] ev   = {fall_ev & demod, rise_ev & demod, term16,
                      term8 & timer8_control_reg_ff[B8_IE]};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer8_control_reg_ff       <= RST_REG8;
         timer_common_control_reg_ff <= RST_REG8;
         timer16_control_reg_ff      <= RST_REG8;
         stat_ff                     <= RST_STAT;
         mask_ff                     <= RST_STAT;
         t8ld_ff                     <= RST_T8LD;
         t16ld_ff                    <= RST_T16LD;
      end else begin
         if (wr8ctl) timer8_control_reg_ff <= wdata_ff[7:0];
         timer_common_control_reg_ff <= {(wrcom ? wdata_ff[7:2] : timer_common_control_reg_ff[7:2]),
                                         nxt_init8, nxt_init16};
         timer16_control_reg_ff <= {nxt_run16,
                                    (wr16ctl ? wdata_ff[B16_SINGLE] : single),
                                    nxt_tout, 5'h00};
         stat_ff <= ev | (stat_ff & ~(wrstat ? wdata_ff[3:0] : 4'h0));
         if (wrmask) mask_ff <= wdata_ff[3:0];
         if (wr8ld)  t8ld_ff <= wdata_ff[7:0];
         if (wr16ld & lane0) t16ld_ff[7:0]  <= wdata_ff[7:0];
         if (wr16ld & lane1) t16ld_ff[15:8] <= wdata_ff[15:8];
      end
   end

   // ======================================================
   // Output levels: idle shows the inverse (16-bit: normal or alternating mode only, else low) so that a start is a visible edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         eight_bit_timer_output_ff  <= 1'b0;
         sixteen_bit_timer_output_ff <= 1'b0;
         run8_d_ff  <= 1'b0;
         run16_d_ff <= 1'b0;
         irq_ff     <= 1'b0;
      end else begin
         run8_d_ff  <= run8;
         run16_d_ff <= run16;
         irq_ff     <= |(stat_ff & mask_ff);
         if (!run8) eight_bit_timer_output_ff <= ~init8;
         else if (start8) eight_bit_timer_output_ff <= init8;
         else if (term8 & ~demod) eight_bit_timer_output_ff <= ~eight_bit_timer_output_ff;
         if (!run16) sixteen_bit_timer_output_ff <= init_eff & ~init16;
         else if (start16) sixteen_bit_timer_output_ff <= init_eff & init16;
         else if (term16 & ~demod) sixteen_bit_timer_output_ff <= ~sixteen_bit_timer_output_ff;
      end
   end

   // Reads of cnt8/cnt16 elsewhere are only by checks below
   assign awready = awready_ff;
   assign wready  = wready_ff;
   assign bvalid  = bvalid_ff;
   assign bresp   = bresp_ff;
   assign arready = arready_ff;
   assign rvalid  = rvalid_ff;
   assign rdata   = rdata_ff;
   assign rresp   = rresp_ff;
   assign irq     = irq_ff;
   assign eight_bit_timer_output   = eight_bit_timer_output_ff;
   assign sixteen_bit_timer_output = sixteen_bit_timer_output_ff;

   // ======================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   t8_idle_level_a: assert property (!run8 |=> eight_bit_timer_output_ff == ~$past(init8))
      else $error("8-bit idle level wrong");
   t8_start_level_a: assert property (start8 |=> eight_bit_timer_output_ff == $past(init8))
      else $error("8-bit start level wrong");
   rise_flag_set_a: assert property (demod && rise_ev |=> init8)
      else $error("rise flag not set");
   fall_flag_set_a: assert property (demod && fall_ev |=> init16)
      else $error("fall flag not set");
   t16_start_level_a: assert property (start16 && init_eff |=> sixteen_bit_timer_output_ff == $past(init16))
      else $error("16-bit start level wrong");
   t16_mode_gate_a: assert property (start16 && !init_eff |=> !sixteen_bit_timer_output_ff)
      else $error("initial level used in wrong mode");
   t16_idle_level_a: assert property (!run16 && init_eff |=> sixteen_bit_timer_output_ff == ~$past(init16))
      else $error("16-bit idle level wrong");
   single_pass_stop_a: assert property (stop16 |=> !run16 ##1 !run16 || $past(wr16ctl))
      else $error("single pass did not stop");
   run_write_a: assert property (wr16ctl && !stop16 |=> run16 == $past(wdata_ff[B16_EN]))
      else $error("run bit write lost");
   timeout_set_a: assert property (term16 |=> timer16_control_reg_ff[B16_TOUT])
      else $error("timeout flag not set");
   t8_wrap_ff_a: assert property (demod && term8 |=> cnt8 == T8_DEMOD_WRAP)
      else $error("8-bit demod wrap wrong");
   t16_reload_a: assert property (term16 && !single && !demod |=> cnt16 == $past(t16ld_ff))
      else $error("16-bit modulo reload wrong");
   flag_keep_a: assert property (demod && rise_ev && wrcom && c1 |=> init8)
      else $error("edge lost on clear");

   wr_done_c: cover property (wr_fire ##[1:4] bvalid_ff && bready);
   rd_done_c: cover property (ar_take ##1 rvalid_ff && rready);
   t16_tout_c: cover property (term16 && !single);
   irq_c: cover property (irq_ff);
endmodule // dct_timer_ctrl

// ---- testbench/tb_dual_counter_timer_output_control.sv ----
// Self-checking bench for the timer pair output and control block
`timescale 1ns/1ns
module tb_dual_counter_timer_output_control;
   import dct_pkg::*;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, timer_in;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata;
   logic        awready, wready, bvalid, arready, rvalid, out8, out16, irq;
   logic [1:0]  bresp, rresp, rsp;
   logic [31:0] rdata, rd;
   int          failures, total_checks, cycles;

   dct_timer_ctrl #(.ADDR_W(8)) dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .timer_in(timer_in), .eight_bit_timer_output(out8),
      .sixteen_bit_timer_output(out16), .irq(irq));

   // ======================================================
   // Clock and hang guard
   initial aclk = 1'b0;
   always #5 aclk = ~aclk;
   // Every scenario is short; 20000 cycles means something is stuck
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         close_out();
      end
   end

   // ======================================================
   // Reporting
   task automatic close_out;
      if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // ======================================================
   // Bus tasks; each starts one edge late so no signal is driven twice in a step
   task automatic wr(input int idx, input logic [31:0] d, output logic [1:0] r);
      logic got;
      got = 1'b0;
      @(posedge aclk);
      awaddr  <= 8'(4 * idx);
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            got = 1'b1;
            r = bresp;
            bready <= 1'b0;
         end
      end
   endtask

   task automatic rdr(input int idx, output logic [31:0] d, output logic [1:0] r);
      logic got;
      got = 1'b0;
      @(posedge aclk);
      araddr  <= 8'(4 * idx);
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!got) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            got = 1'b1;
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
      end
   endtask

   // Write expecting an OKAY answer
   task automatic w(input int idx, input logic [31:0] d);
      wr(idx, d, rsp);
      chk("bresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
   endtask

   // Read and compare one register
   task automatic r_chk(input string name, input int idx, input logic [31:0] exp);
      rdr(idx, rd, rsp);
      chk(name, rd, exp);
      chk("rresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic set_in(input logic v);
      @(posedge aclk);
      timer_in <= v;
   endtask

   // ======================================================
   // Main sequence
   initial begin
      aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
      rready = 1'b0; timer_in = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
      failures = 0; total_checks = 0; cycles = 0;
      idle(2);
      aresetn <= 1'b1;
      idle(2);
      // Reset values and idle levels with both level bits at zero
      r_chk("t8ctl", IDX_T8CTL, {24'h0, RST_REG8});
      r_chk("common", IDX_COMMON, {24'h0, RST_REG8});
      r_chk("t16ctl", IDX_T16CTL, {24'h0, RST_REG8});
      r_chk("status", IDX_STAT, {28'h0, RST_STAT});
      r_chk("mask", IDX_MASK, {28'h0, RST_STAT});
      r_chk("t8ld", IDX_T8LD, {24'h0, RST_T8LD});
      r_chk("t16ld", IDX_T16LD, {16'h0, RST_T16LD});
      chk("out8_idle", {31'h0, out8}, 32'h1);
      chk("out16_idle", {31'h0, out16}, 32'h1);
      // Unmapped place answers with an error and reads zero
      rdr(7, rd, rsp);
      chk("unmapped_rd", rd, 32'h0);
      chk("unmapped_rresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(7, 32'hFF, rsp);
      chk("unmapped_bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
      w(IDX_MASK, 32'hF);
      r_chk("mask_rw", IDX_MASK, 32'hF);
      w(IDX_MASK, 32'h0);
      // Long reloads keep the outputs at their start level while checked
      w(IDX_T8LD, 32'h40);
      w(IDX_T16LD, 32'h1234);
      r_chk("t16ld_rw", IDX_T16LD, 32'h1234);
      for (int v = 0; v < 2; v++) begin
         w(IDX_COMMON, {30'h0, 1'(v), 1'(v)});
         idle(3);
         chk("out8_off", {31'h0, out8}, {31'h0, ~1'(v)});
         chk("out16_off", {31'h0, out16}, {31'h0, ~1'(v)});
         w(IDX_T8CTL, 32'h80);
         w(IDX_T16CTL, 32'h80);
         idle(3);
         chk("out8_start", {31'h0, out8}, {31'h0, 1'(v)});
         chk("out16_start", {31'h0, out16}, {31'h0, 1'(v)});
         r_chk("t16_run", IDX_T16CTL, 32'h80);
         w(IDX_T8CTL, 32'h0);
         w(IDX_T16CTL, 32'h0);
         r_chk("t16_stop", IDX_T16CTL, 32'h0);
         idle(3);
         chk("out8_back", {31'h0, out8}, {31'h0, ~1'(v)});
      end
      // Alternating mode honours the level bit, output mode 2 ignores it
      w(IDX_COMMON, 32'h4);
      idle(3);
      chk("out16_alt", {31'h0, out16}, 32'h1);
      w(IDX_COMMON, 32'h8);
      idle(3);
      chk("out16_om2", {31'h0, out16}, 32'h0);
      w(IDX_COMMON, 32'h9);
      idle(3);
      chk("out16_om2_hi", {31'h0, out16}, 32'h0);
      w(IDX_T16CTL, 32'h80);
      idle(3);
      chk("out16_om2_run", {31'h0, out16}, 32'h0);
      w(IDX_T16CTL, 32'h0);
      // Single pass ends by itself and leaves the timeout flag
      w(IDX_COMMON, 32'h0);
      w(IDX_T16LD, 32'h2);
      w(IDX_T16CTL, 32'hC0);
      idle(40);
      r_chk("single_end", IDX_T16CTL, 32'h60);
      r_chk("stat_tout", IDX_STAT, 32'h2);
      w(IDX_T16CTL, 32'h40);
      r_chk("tout_keep", IDX_T16CTL, 32'h60);
      w(IDX_T16CTL, 32'h60);
      r_chk("tout_clr", IDX_T16CTL, 32'h40);
      // Modulo-N keeps running after a timeout
      w(IDX_T16CTL, 32'h80);
      idle(40);
      r_chk("modulo_run", IDX_T16CTL, 32'hA0);
      w(IDX_T16CTL, 32'h0);
      w(IDX_T16CTL, 32'h20);
      r_chk("modulo_stop", IDX_T16CTL, 32'h0);
      w(IDX_STAT, 32'hF);
      // Demodulation edge flags: sticky, cleared only by a one
      w(IDX_COMMON, 32'h80);
      set_in(1'b1);
      idle(4);
      r_chk("rise_set", IDX_COMMON, 32'h82);
      w(IDX_COMMON, 32'h80);
      r_chk("rise_keep", IDX_COMMON, 32'h82);
      set_in(1'b0);
      idle(4);
      r_chk("fall_set", IDX_COMMON, 32'h83);
      w(IDX_COMMON, 32'h82);
      r_chk("rise_clr", IDX_COMMON, 32'h81);
      w(IDX_COMMON, 32'h81);
      r_chk("fall_clr", IDX_COMMON, 32'h80);
      r_chk("stat_edges", IDX_STAT, 32'hC);
      // An edge landing in the clearing cycle keeps the flag set
      fork
         w(IDX_COMMON, 32'h82);
         begin
            idle(1);
            set_in(1'b1);
         end
      join
      r_chk("rise_race", IDX_COMMON, 32'h82);
      w(IDX_COMMON, 32'h82);
      r_chk("rise_clr2", IDX_COMMON, 32'h80);
      w(IDX_STAT, 32'hF);
      r_chk("stat_clr", IDX_STAT, 32'h0);
      // 8-bit demodulation wrap raises the interrupt, then counts on from FFh
      w(IDX_T8LD, 32'h2);
      w(IDX_T8CTL, 32'h82);
      idle(40);
      r_chk("t8_wrap", IDX_STAT, 32'h1);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      w(IDX_MASK, 32'h1);
      idle(3);
      chk("irq_on", {31'h0, irq}, 32'h1);
      w(IDX_STAT, 32'h1);
      idle(3);
      chk("irq_off", {31'h0, irq}, 32'h0);
      // A reload from 2 would wrap again long before this; from FFh it cannot
      idle(100);
      r_chk("t8_from_ff", IDX_STAT, 32'h0);
      w(IDX_T8CTL, 32'h0);
      close_out();
   end
endmodule // tb_dual_counter_timer_output_control
